// File: common/dri_pkg.sv
package dri_pkg;
	localparam int SLOTS = 6;
	localparam int NRES = 7;
	localparam logic [3:0] MAX_PAIR_LEN = 4'hF;
	localparam logic [4:0] SP_ID = 5'h04;
	localparam logic [15:0] SP_STEP = 16'h0008;
	localparam int PAUSE_CYCLES = 64;
	localparam logic [6:0] PAUSE_COUNT = 7'(PAUSE_CYCLES);
	// resource class bit positions
	localparam int R_DIV = 0;
	localparam int R_MUL = 1;
	localparam int R_FPLD = 2;
	localparam int R_BR = 3;
	localparam int R_LDST = 4;
	localparam int R_LDALU = 5;
	localparam int R_ALU = 6;
	localparam logic [NRES-1:0][2:0] RES_LIMIT = {3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1};
	// flag field positions
	localparam int F_CF = 0;
	localparam int F_ZF = 3;
	localparam logic [5:0] FLAGS_ZERO = 6'h00;
	localparam logic [5:0] FLAGS_ZF_ONLY = 6'h08;

	typedef enum logic [4:0] {
		OP_OTHER, OP_XOR, OP_SUB, OP_CMP, OP_SBB, OP_TEST, OP_ADD, OP_INC, OP_DEC,
		OP_OR, OP_AND, OP_SIMD_ZERO, OP_SIMD_ONES, OP_MOV, OP_JCC, OP_JCXZ,
		OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_PAUSE
	} dri_opc_t;
	typedef enum logic [2:0] {FM_NONE, FM_RR, FM_RI, FM_RM, FM_MR, FM_MI} dri_form_t;
	typedef enum logic [1:0] {SPU_NONE, SPU_TRACKED_REF, SPU_OTHER_REF, SPU_OTHER_UPD} dri_spu_t;
	typedef enum logic [2:0] {ID_NONE, ID_ZERO, ID_CMP_SELF, ID_SBB_CARRY, ID_ONES} dri_idiom_t;

	typedef struct packed {
		dri_opc_t opc;
		dri_form_t form;
		logic [4:0] dst;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [3:0] len;
		logic has_imm;
		logic has_disp;
		logic rip_rel;
		logic cc_uses_cf;
		logic [3:0] cond;
		logic [15:0] imm16;
		dri_spu_t sp_use;
		logic [NRES-1:0] res;
	} dri_instr_t;

	typedef struct packed {
		logic valid;
		dri_opc_t opc;
		logic [4:0] dst;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic dep_a;
		logic dep_b;
		dri_idiom_t idiom;
		logic [5:0] flags;
		logic zero_lat;
		logic fused;
		logic [3:0] cond;
		logic [15:0] sp_delta;
		logic sp_sync;
		logic [NRES-1:0] res;
	} dri_mop_t;
endpackage

// File: design/dri_decode_rename.sv
`timescale 1ns/1ps
module dri_decode_rename (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// decoded instruction stream in
	input wire logic in_valid,
	input wire dri_pkg::dri_instr_t in_instr,
	input wire logic in_flush,
	output logic in_ready,
	// dispatch group out
	output logic grp_valid,
	output dri_pkg::dri_mop_t [dri_pkg::SLOTS-1:0] grp_slots,
	output logic [2:0] grp_count,
	input wire logic grp_ready,
	// status
	output logic pause_active,
	output logic sp_tracked
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic in_ready;
		logic inq_v;
		dri_pkg::dri_instr_t inq;
		logic pend_v;
		dri_pkg::dri_instr_t pend;
		dri_pkg::dri_mop_t [dri_pkg::SLOTS-1:0] bld;
		logic [2:0] bld_n;
		logic [dri_pkg::NRES-1:0][2:0] bld_cnt;
		logic bld_pause;
		logic out_v;
		dri_pkg::dri_mop_t [dri_pkg::SLOTS-1:0] out;
		logic [2:0] out_n;
		logic out_pause;
		logic [6:0] pause_cnt;
		logic pause_on;
		logic sp_trk;
		logic [15:0] sp_delta;
	} dri_state_t;

	dri_state_t st_reg;
	dri_state_t st_next;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic is_writer(input dri_pkg::dri_opc_t o);
		return o inside {dri_pkg::OP_CMP, dri_pkg::OP_TEST, dri_pkg::OP_SUB, dri_pkg::OP_ADD,
			dri_pkg::OP_INC, dri_pkg::OP_DEC, dri_pkg::OP_OR, dri_pkg::OP_AND,
			dri_pkg::OP_XOR};
	endfunction

	function automatic logic can_fuse(input dri_pkg::dri_instr_t w, input dri_pkg::dri_instr_t b);
		logic form_ok;
		logic [4:0] pair_len;
		form_ok = w.form inside {dri_pkg::FM_RR, dri_pkg::FM_RI, dri_pkg::FM_RM};
		if ((w.opc == dri_pkg::OP_CMP || w.opc == dri_pkg::OP_TEST) &&
			(w.form inside {dri_pkg::FM_MR, dri_pkg::FM_MI})) begin
			form_ok = 1'b1;
		end
		pair_len = {1'b0, w.len} + {1'b0, b.len};
		can_fuse = is_writer(w.opc) && form_ok &&
			b.opc == dri_pkg::OP_JCC &&
			!((w.opc == dri_pkg::OP_INC || w.opc == dri_pkg::OP_DEC) && b.cc_uses_cf) &&
			!(w.has_imm && w.has_disp) &&
			!w.rip_rel &&
			pair_len <= {1'b0, dri_pkg::MAX_PAIR_LEN};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// emission choice and rename
	logic fuse;
	logic emit_v;
	logic consume_inq;
	logic emit_clears_pend;
	dri_pkg::dri_instr_t ei;
	dri_pkg::dri_mop_t mop;
	dri_pkg::dri_mop_t sync_mop;
	logic need_sync;
	logic [1:0] n_emit;
	logic new_trk;
	logic [15:0] new_delta;
	logic same_src;
	logic reg_form;
	logic sp_supported_upd;
	logic sp_unsupported;
	logic [dri_pkg::NRES-1:0][1:0] add_cnt;
	logic fits;
	logic close_req;
	logic out_free;

	always_comb begin
		fuse = st_reg.pend_v && st_reg.inq_v && can_fuse(st_reg.pend, st_reg.inq);
		emit_v = st_reg.pend_v && (st_reg.inq_v || in_flush);
		consume_inq = st_reg.inq_v;
		emit_clears_pend = fuse || !st_reg.inq_v;
		ei = st_reg.pend;

		reg_form = ei.form == dri_pkg::FM_RR;
		same_src = reg_form && (ei.src_a == ei.src_b);

		mop = '0;
		mop.valid = 1'b1;
		mop.opc = ei.opc;
		mop.dst = ei.dst;
		mop.src_a = ei.src_a;
		mop.src_b = ei.src_b;
		mop.dep_a = 1'b1;
		mop.dep_b = ei.form != dri_pkg::FM_RI && ei.form != dri_pkg::FM_MI;
		mop.idiom = dri_pkg::ID_NONE;
		mop.cond = ei.cond;
		mop.res = ei.res;
		if (ei.res[dri_pkg::R_LDALU]) begin
			mop.res[dri_pkg::R_ALU] = 1'b1;
		end
		if (fuse) begin
			mop.fused = 1'b1;
			mop.cond = st_reg.inq.cond;
			mop.res[dri_pkg::R_BR] = 1'b1;
		end

		if (same_src) begin
			case (ei.opc)
				dri_pkg::OP_XOR, dri_pkg::OP_SUB: begin
					mop.idiom = dri_pkg::ID_ZERO;
					mop.flags = dri_pkg::FLAGS_ZERO;
					mop.zero_lat = 1'b1;
				end
				dri_pkg::OP_CMP: begin
					mop.idiom = dri_pkg::ID_CMP_SELF;
					mop.flags = dri_pkg::FLAGS_ZF_ONLY;
					mop.zero_lat = 1'b1;
				end
				dri_pkg::OP_SBB: begin
					mop.idiom = dri_pkg::ID_SBB_CARRY;
				end
				dri_pkg::OP_SIMD_ZERO: begin
					mop.idiom = dri_pkg::ID_ZERO;
					mop.zero_lat = 1'b1;
				end
				dri_pkg::OP_SIMD_ONES: begin
					mop.idiom = dri_pkg::ID_ONES;
					mop.zero_lat = 1'b1;
				end
				default: begin
				end
			endcase
			if (mop.idiom != dri_pkg::ID_NONE) begin
				// register contents are never read; sbb still reads the carry
				mop.dep_a = 1'b0;
				mop.dep_b = 1'b0;
			end
		end
		if (ei.opc == dri_pkg::OP_MOV && reg_form) begin
			mop.zero_lat = 1'b1;
			mop.res = '0;
		end

		// stack pointer tracking
		new_trk = st_reg.sp_trk;
		new_delta = st_reg.sp_delta;
		sp_supported_upd = 1'b0;
		sp_unsupported = ei.sp_use inside {dri_pkg::SPU_OTHER_REF, dri_pkg::SPU_OTHER_UPD};
		case (ei.opc)
			dri_pkg::OP_PUSH: begin
				if (reg_form && ei.src_a == dri_pkg::SP_ID) begin
					sp_unsupported = 1'b1;
				end else begin
					sp_supported_upd = 1'b1;
				end
			end
			dri_pkg::OP_POP: begin
				if (ei.form == dri_pkg::FM_RR && ei.dst == dri_pkg::SP_ID) begin
					sp_unsupported = 1'b1;
				end else begin
					sp_supported_upd = 1'b1;
				end
			end
			dri_pkg::OP_CALL, dri_pkg::OP_RET: begin
				sp_supported_upd = 1'b1;
			end
			default: begin
			end
		endcase
		need_sync = sp_unsupported && st_reg.sp_trk;
		sync_mop = '0;
		sync_mop.valid = 1'b1;
		sync_mop.opc = dri_pkg::OP_OTHER;
		sync_mop.dst = dri_pkg::SP_ID;
		sync_mop.src_a = dri_pkg::SP_ID;
		sync_mop.dep_a = 1'b1;
		sync_mop.sp_delta = st_reg.sp_delta;
		sync_mop.sp_sync = 1'b1;
		sync_mop.res[dri_pkg::R_ALU] = 1'b1;
		if (sp_unsupported) begin
			new_trk = 1'b0;
			new_delta = '0;
		end else if (sp_supported_upd) begin
			// no read of the architectural stack pointer register
			mop.sp_delta = st_reg.sp_delta;
			mop.dep_a = ei.opc == dri_pkg::OP_PUSH && ei.form == dri_pkg::FM_RR;
			new_trk = 1'b1;
			case (ei.opc)
				dri_pkg::OP_PUSH, dri_pkg::OP_CALL: begin
					new_delta = st_reg.sp_delta - dri_pkg::SP_STEP;
				end
				dri_pkg::OP_RET: begin
					new_delta = st_reg.sp_delta + dri_pkg::SP_STEP + ei.imm16;
				end
				default: begin
					new_delta = st_reg.sp_delta + dri_pkg::SP_STEP;
				end
			endcase
		end else if (ei.sp_use == dri_pkg::SPU_TRACKED_REF) begin
			mop.sp_delta = st_reg.sp_delta;
		end
		n_emit = need_sync ? 2'h2 : 2'h1;

		// window accounting for the group being built
		for (int i = 0; i < dri_pkg::NRES; i++) begin
			add_cnt[i] = {1'b0, mop.res[i]} + (need_sync ? {1'b0, sync_mop.res[i]} : 2'h0);
		end
		fits = !st_reg.bld_pause &&
			({1'b0, st_reg.bld_n} + {2'b0, n_emit} <= 4'(dri_pkg::SLOTS));
		for (int i = 0; i < dri_pkg::NRES; i++) begin
			if ({1'b0, st_reg.bld_cnt[i]} + {2'b0, add_cnt[i]} > {1'b0, dri_pkg::RES_LIMIT[i]}) begin
				fits = 1'b0;
			end
		end

		close_req = st_reg.bld_n != 3'h0 &&
			((emit_v && !fits) || st_reg.bld_pause || st_reg.bld_n == 3'(dri_pkg::SLOTS) ||
			(in_flush && !st_reg.inq_v && !st_reg.pend_v));

		////////////////////////////////////////////////////////////////////////
		st_next = st_reg;

		// output group handshake and pause hold-off
		if (st_reg.pause_cnt != 7'h00) begin
			st_next.pause_cnt = st_reg.pause_cnt - 7'h01;
		end
		if (st_reg.out_v && grp_ready) begin
			st_next.out_v = 1'b0;
			if (st_reg.out_pause) begin
				st_next.pause_cnt = dri_pkg::PAUSE_COUNT;
			end
		end
		// registered copy so the status pin comes from a flop
		st_next.pause_on = st_next.pause_cnt != 7'h00;
		out_free = !st_next.out_v && st_reg.pause_cnt == 7'h00;

		if (close_req) begin
			if (out_free) begin
				st_next.out_v = 1'b1;
				st_next.out = st_reg.bld;
				st_next.out_n = st_reg.bld_n;
				st_next.out_pause = st_reg.bld_pause;
				st_next.bld = '0;
				st_next.bld_n = 3'h0;
				st_next.bld_cnt = '0;
				st_next.bld_pause = 1'b0;
			end
		end else if (emit_v && fits) begin
			if (need_sync) begin
				st_next.bld[st_reg.bld_n] = sync_mop;
				st_next.bld[st_reg.bld_n + 3'h1] = mop;
			end else begin
				st_next.bld[st_reg.bld_n] = mop;
			end
			st_next.bld_n = st_reg.bld_n + {1'b0, n_emit};
			for (int i = 0; i < dri_pkg::NRES; i++) begin
				st_next.bld_cnt[i] = st_reg.bld_cnt[i] + {1'b0, add_cnt[i]};
			end
			st_next.bld_pause = ei.opc == dri_pkg::OP_PAUSE;
			st_next.sp_trk = new_trk;
			st_next.sp_delta = new_delta;
			if (emit_clears_pend) begin
				st_next.pend_v = 1'b0;
			end else begin
				st_next.pend = st_reg.inq;
			end
			if (consume_inq) begin
				st_next.inq_v = 1'b0;
			end
		end else if (st_reg.inq_v && !st_reg.pend_v) begin
			st_next.pend_v = 1'b1;
			st_next.pend = st_reg.inq;
			st_next.inq_v = 1'b0;
		end

		// input stage: in_ready is registered, so a single holding entry
		if (st_reg.in_ready && in_valid) begin
			st_next.inq_v = 1'b1;
			st_next.inq = in_instr;
		end
		st_next.in_ready = !st_next.inq_v;

		if (reset) begin
			st_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////
	assign in_ready = st_reg.in_ready;
	assign grp_valid = st_reg.out_v;
	assign grp_slots = st_reg.out;
	assign grp_count = st_reg.out_n;
	assign pause_active = st_reg.pause_on;
	assign sp_tracked = st_reg.sp_trk;
endmodule // dri_decode_rename

// File: tb/dri_decode_rename_asserts.sv
`timescale 1ns/1ps
module dri_decode_rename_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// input stream
	input wire logic in_valid,
	input wire dri_pkg::dri_instr_t in_instr,
	input wire logic in_flush,
	input wire logic in_ready,
	// dispatch group
	input wire logic grp_valid,
	input wire dri_pkg::dri_mop_t [dri_pkg::SLOTS-1:0] grp_slots,
	input wire logic [2:0] grp_count,
	input wire logic grp_ready,
	// status
	input wire logic pause_active,
	input wire logic sp_tracked
);
	logic [5:0] bad;
	logic has_pause;
	logic [7:0] run_reg;
	int cnt [dri_pkg::NRES];
	dri_pkg::dri_mop_t m;
	always_comb begin
		bad = '0;
		has_pause = 1'b0;
		cnt = '{default: 0};
		m = '0;
		for (int k = 0; k < dri_pkg::SLOTS; k++) begin
			m = grp_slots[k];
			bad[0] |= m.valid != (k < int'(grp_count));
			if (m.valid) begin
				for (int r = 0; r < dri_pkg::NRES; r++) cnt[r] += int'(m.res[r]);
				has_pause |= m.opc == dri_pkg::OP_PAUSE;
				case (m.idiom)
					dri_pkg::ID_ZERO: bad[1] |= !m.zero_lat || m.dep_a || m.dep_b
						|| (m.opc inside {dri_pkg::OP_XOR, dri_pkg::OP_SUB} && m.flags != '0);
					dri_pkg::ID_CMP_SELF: bad[2] |= !m.zero_lat || m.flags != dri_pkg::FLAGS_ZF_ONLY;
					dri_pkg::ID_SBB_CARRY: bad[3] |= m.dep_a || m.dep_b;
					dri_pkg::ID_ONES: bad[4] |= m.dep_a || m.dep_b;
					default: ;
				endcase
			end
		end
		for (int r = 0; r < dri_pkg::NRES; r++) bad[5] |= cnt[r] > int'(dri_pkg::RES_LIMIT[r]);
	end
	// length of the current pause hold
	always_ff @(posedge clk) begin
		run_reg <= (reset || !pause_active) ? 8'h00 : run_reg + 8'h01;
	end
	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_take; grp_valid && grp_ready; endsequence
	sequence s_pause_take; s_take ##0 has_pause; endsequence
	property p_count; grp_valid |-> grp_count inside {[3'h1:3'h6]} && !bad[0]; endproperty
	property p_hold; grp_valid && !grp_ready |=> grp_valid && $stable(grp_slots); endproperty
	property p_zero; grp_valid |-> !bad[1]; endproperty
	property p_cmp; grp_valid |-> !bad[2]; endproperty
	property p_sbb; grp_valid |-> !bad[3]; endproperty
	property p_ones; grp_valid |-> !bad[4]; endproperty
	property p_res; grp_valid |-> !bad[5]; endproperty
	property p_pause; s_pause_take |=> pause_active [*8]; endproperty
	property p_halt; pause_active |-> !grp_valid; endproperty
	property p_plen; $fell(pause_active) |-> run_reg inside {[8'h3F:8'h41]}; endproperty
	a_count: assert property (p_count) else $error("bad group count");
	a_hold: assert property (p_hold) else $error("group changed");
	a_zero: assert property (p_zero) else $error("bad zero idiom");
	a_cmp: assert property (p_cmp) else $error("bad compare idiom");
	a_sbb: assert property (p_sbb) else $error("bad borrow idiom");
	a_ones: assert property (p_ones) else $error("bad ones idiom");
	a_res: assert property (p_res) else $error("class limit broken");
	a_pause: assert property (p_pause) else $error("no pause hold");
	a_halt: assert property (p_halt) else $error("group during pause");
	a_plen: assert property (p_plen) else $error("bad pause length");
endmodule // dri_decode_rename_asserts

bind dri_decode_rename dri_decode_rename_asserts u_dri_decode_rename_asserts (.clk(clk),
	.reset(reset), .in_valid(in_valid), .in_instr(in_instr), .in_flush(in_flush),
	.in_ready(in_ready), .grp_valid(grp_valid), .grp_slots(grp_slots), .grp_count(grp_count),
	.grp_ready(grp_ready), .pause_active(pause_active), .sp_tracked(sp_tracked));

// File: tb/dri_decode_rename_tb.sv
`timescale 1ns/1ps
module dri_decode_rename_tb;
	logic clk;
	logic reset = 1'b1;
	logic in_valid = 1'b0;
	logic in_flush = 1'b0;
	logic slow = 1'b0;
	logic trk = 1'b0;
	logic in_ready;
	logic grp_valid;
	logic grp_ready;
	logic pause_active;
	logic sp_tracked;
	logic [2:0] grp_count;
	dri_pkg::dri_instr_t in_instr = '0;
	dri_pkg::dri_instr_t i;
	dri_pkg::dri_instr_t seq [$];
	dri_pkg::dri_mop_t [dri_pkg::SLOTS-1:0] grp_slots;
	logic [16:0] notes [$];
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	dri_decode_rename u_dri_decode_rename (.clk(clk), .reset(reset), .in_valid(in_valid),
		.in_instr(in_instr), .in_flush(in_flush), .in_ready(in_ready), .grp_valid(grp_valid),
		.grp_slots(grp_slots), .grp_count(grp_count), .grp_ready(grp_ready),
		.pause_active(pause_active), .sp_tracked(sp_tracked));
	dri_sched_model u_dri_sched_model (.clk(clk), .reset(reset), .slow(slow), .grp_ready(grp_ready));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	////////////////////////////////////////
	function automatic logic [16:0] sig(dri_pkg::dri_opc_t o, dri_pkg::dri_idiom_t d, logic f,
		logic [5:0] fl, logic z, logic s);
		logic fk;
		fk = d == dri_pkg::ID_CMP_SELF || (d == dri_pkg::ID_ZERO && o inside {dri_pkg::OP_XOR, dri_pkg::OP_SUB});
		return s ? 17'h10000 : {1'b0, f, z, d, o, fl & {6{fk}}};
	endfunction
	task automatic chk(logic [16:0] got, logic [16:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic fuses(dri_pkg::dri_instr_t a, dri_pkg::dri_instr_t b);
		logic w;
		w = a.opc inside {[dri_pkg::OP_XOR:dri_pkg::OP_CMP], [dri_pkg::OP_TEST:dri_pkg::OP_AND]}
			&& a.form inside {dri_pkg::FM_RR, dri_pkg::FM_RI, dri_pkg::FM_RM};
		w |= a.opc inside {dri_pkg::OP_CMP, dri_pkg::OP_TEST} && a.form > dri_pkg::FM_RM;
		w &= !(a.opc inside {dri_pkg::OP_INC, dri_pkg::OP_DEC} && b.cc_uses_cf);
		w &= !(a.has_imm && a.has_disp) && !a.rip_rel;
		return w && b.opc == dri_pkg::OP_JCC && 5'(a.len) + 5'(b.len) <= 5'h0F;
	endfunction
	function automatic logic [16:0] note(dri_pkg::dri_instr_t a, logic fu);
		dri_pkg::dri_idiom_t d;
		d = dri_pkg::ID_NONE;
		if (a.form == dri_pkg::FM_RR && a.src_a == a.src_b) begin
			case (a.opc)
				dri_pkg::OP_XOR, dri_pkg::OP_SUB, dri_pkg::OP_SIMD_ZERO: d = dri_pkg::ID_ZERO;
				dri_pkg::OP_CMP: d = dri_pkg::ID_CMP_SELF;
				dri_pkg::OP_SBB: d = dri_pkg::ID_SBB_CARRY;
				dri_pkg::OP_SIMD_ONES: d = dri_pkg::ID_ONES;
				default: ;
			endcase
		end
		return sig(a.opc, d, fu, d == dri_pkg::ID_ZERO ? 6'h00 : dri_pkg::FLAGS_ZF_ONLY,
			d inside {dri_pkg::ID_ZERO, dri_pkg::ID_CMP_SELF, dri_pkg::ID_ONES}
			|| (a.opc == dri_pkg::OP_MOV && a.form == dri_pkg::FM_RR), 1'b0);
	endfunction
	function automatic dri_pkg::dri_instr_t rnd(logic br);
		dri_pkg::dri_instr_t r;
		r = '0;
		r.opc = br ? ($urandom % 4 == 0 ? dri_pkg::OP_JCXZ : dri_pkg::OP_JCC) : dri_pkg::dri_opc_t'($urandom % 14);
		r.form = dri_pkg::dri_form_t'($urandom % 6);
		r.dst = 5'($urandom % 4);
		r.src_a = 5'($urandom % 4);
		r.src_b = 5'($urandom % 4);
		r.len = 4'($urandom % 8 + 1);
		r.has_imm = 1'($urandom);
		r.has_disp = 1'($urandom);
		r.rip_rel = $urandom % 4 == 0;
		r.cc_uses_cf = 1'($urandom);
		r.cond = 4'($urandom);
		r.res = 7'($urandom);
		return r;
	endfunction
	task automatic send(dri_pkg::dri_instr_t x);
		@(negedge clk);
		in_instr = x;
		in_valid = 1'b1;
		while (!in_ready) @(negedge clk);
		@(negedge clk);
		in_valid = 1'b0;
	endtask
	task automatic run();
		logic fu;
		logic sup;
		dri_pkg::dri_instr_t a;
		for (int k = 0; k < seq.size(); k++) begin
			a = seq[k];
			sup = a.opc inside {[dri_pkg::OP_PUSH:dri_pkg::OP_RET]} && !(a.form == dri_pkg::FM_RR
				&& ((a.opc == dri_pkg::OP_PUSH && a.src_a == 5'h04) || (a.opc == dri_pkg::OP_POP && a.dst == 5'h04)));
			sup &= a.sp_use < dri_pkg::SPU_OTHER_REF;
			if (!sup && (a.sp_use > dri_pkg::SPU_TRACKED_REF || a.opc inside {[dri_pkg::OP_PUSH:dri_pkg::OP_RET]})) begin
				if (trk) notes.push_back(17'h10000);
				trk = 1'b0;
			end
			trk |= sup;
			fu = k + 1 < seq.size() && fuses(a, seq[k + 1]);
			notes.push_back(note(a, fu));
			k += int'(fu);
		end
		foreach (seq[k]) send(seq[k]);
		@(negedge clk);
		in_flush = 1'b1;
		while (notes.size() != 0) @(negedge clk);
		in_flush = 1'b0;
		seq.delete();
	endtask
	task automatic test_done();
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end else if (!reset && grp_valid && grp_ready) begin
			for (int k = 0; k < int'(grp_count); k++) begin
				chk(sig(grp_slots[k].opc, grp_slots[k].idiom, grp_slots[k].fused, grp_slots[k].flags,
					grp_slots[k].zero_lat, grp_slots[k].sp_sync), notes.size() ? notes.pop_front() : 17'h1FFFF);
			end
		end
	end
	initial begin
		void'($urandom(32'hE565D35D));
		repeat (2) @(negedge clk);
		reset = 1'b0;
		i = '0;
		i.form = dri_pkg::FM_RR;
		i.src_a = 5'h01;
		i.opc = dri_pkg::OP_PUSH;
		seq.push_back(i);
		i.opc = dri_pkg::OP_ADD;
		i.sp_use = dri_pkg::SPU_TRACKED_REF;
		seq.push_back(i);
		i.opc = dri_pkg::OP_OTHER;
		i.sp_use = dri_pkg::SPU_OTHER_UPD;
		seq.push_back(i);
		run();
		chk(17'(sp_tracked), 17'h00000);
		seq = '{i, i, i, i, i};
		seq[0].sp_use = dri_pkg::SPU_OTHER_REF;
		seq[1].opc = dri_pkg::OP_CALL;
		seq[2].opc = dri_pkg::OP_POP;
		seq[2].dst = 5'h04;
		seq[3].opc = dri_pkg::OP_RET;
		seq[4].opc = dri_pkg::OP_PAUSE;
		for (int k = 1; k < 5; k++) seq[k].sp_use = dri_pkg::SPU_NONE;
		seq.push_back(seq[1]);
		run();
		chk(17'(sp_tracked), 17'h00001);
		for (int r = 0; r < 40; r++) begin
			slow = r[0];
			repeat (3) begin
				seq.push_back(rnd(1'b0));
				i = rnd(1'($urandom));
				if (i.opc inside {dri_pkg::OP_JCC, dri_pkg::OP_JCXZ}) seq[$].src_b = seq[$].src_a ^ 5'h01;
				seq.push_back(i);
			end
			run();
		end
		test_done();
	end
endmodule // dri_decode_rename_tb

// File: tb/dri_sched_model.sv
`timescale 1ns/1ps
module dri_sched_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// stall mode
	input wire logic slow,
	// dispatch handshake
	output logic grp_ready
);
	initial grp_ready = 1'b0;
	// prompt or randomly stalling acceptor
	always @(negedge clk) begin
		grp_ready <= !reset && (!slow || $urandom % 3 == 0);
	end
endmodule // dri_sched_model
